//--- fsp_pkg.sv
// Contract
// - While the lock bit is 1 and the write-protect pin is low, the status write command is not carried out and the nonvolatile bits stay as they are.
// - Only a high level on the write-protect pin ends the locked state; no command can end it. A reset also ends it here, as it loads the lock bit with 0.
// - Status bit 7 is the nonvolatile lock bit, 0 by default, and 1 blocks status writes while the pin is low.
// - Status bit 5 picks where the protected area sits, 0 (default) at the top of the array and 1 at the bottom.
// - The block-protect field is status bit 6 (top bit) with bits 4 to 2, and any nonzero value makes its area refuse program and erase.
// - The write-enable latch at status bit 1 is clear after reset and must be set by the write-enable command before any write, program or erase.
// - Status bit 0 is 1 while a status write, program or erase runs and 0 when the device is ready.
// - The busy bit always equals the inverse of the ready bit 7 of the flag status register.
// - A whole-die erase runs only when the protect field is zero and is refused otherwise.
// - Field values 1 to 9 protect 1, 2, 4 up to 256 sectors from sector 511 down (top) or from sector 0 up (bottom), 10 to 15 protect all and 0 none.
// - The die spans byte addresses 0 to 01ff_ffff in 512 sectors of 64KB, each of two 32KB and sixteen 4KB subsectors.
// - A program or erase aimed at a protected sector leaves the array alone and sets the protection error bit 1 of the flag status register.
package fsp_pkg;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [7:0] OP_PP = 8'h02;
  localparam logic [7:0] OP_SE64 = 8'hd8;
  localparam logic [7:0] OP_SE32 = 8'h52;
  localparam logic [7:0] OP_SE4 = 8'h20;
  localparam logic [7:0] OP_DIE = 8'hc4;
  localparam logic [7:0] OP_RDFS = 8'h70;
  localparam logic [7:0] OP_CLFS = 8'h50;

  localparam int SR_LOCK = 7;
  localparam int SR_BP3 = 6;
  localparam int SR_TB = 5;
  localparam int SR_BP_HI = 4;
  localparam int SR_BP_LO = 2;
  localparam int SR_WEL = 1;
  localparam int SR_BUSY = 0;
  localparam logic [5:0] SR_NV_RESET = 6'h00;

  localparam int FS_READY = 7;
  localparam int FS_ERASE = 5;
  localparam int FS_PROG = 4;
  localparam int FS_PROT = 1;
  localparam int FS_ADDR4 = 0;

  localparam int ADDR_W = 25;
  localparam int SECTOR_W = 9;
  localparam int SECTOR_LSB = 16;
  localparam logic [9:0] SECTOR_COUNT = 10'h200;
  localparam logic [3:0] BP_ALL_MIN = 4'ha;
  localparam logic [2:0] ADDR_BYTES = 3'h4;

  localparam logic [15:0] T_WRSR = 16'h0040;
  localparam logic [15:0] T_PROG = 16'h0100;
  localparam logic [15:0] T_SE4 = 16'h0400;
  localparam logic [15:0] T_SE32 = 16'h0600;
  localparam logic [15:0] T_SE64 = 16'h0800;
  localparam logic [15:0] T_DIE = 16'h2000;

  typedef enum logic [2:0] {
    FSP_ST_IDLE = 3'b000,
    FSP_ST_OPCODE = 3'b001,
    FSP_ST_ADDR = 3'b010,
    FSP_ST_DATA = 3'b011,
    FSP_ST_READ = 3'b100
  } fsp_state_t;

  typedef enum logic [2:0] {
    FSP_OP_NONE = 3'b000,
    FSP_OP_WRSR = 3'b001,
    FSP_OP_PROG = 3'b010,
    FSP_OP_ERASE4 = 3'b011,
    FSP_OP_ERASE32 = 3'b100,
    FSP_OP_ERASE64 = 3'b101,
    FSP_OP_DIE = 3'b110
  } fsp_op_t;

  function automatic logic fsp_has_addr(input logic [7:0] op);
    fsp_has_addr = (op == OP_PP) || (op == OP_SE64) || (op == OP_SE32) || (op == OP_SE4);
  endfunction

  function automatic logic fsp_is_read(input logic [7:0] op);
    fsp_is_read = (op == OP_RDSR) || (op == OP_RDFS);
  endfunction
endpackage

//--- fsp_protect_decode.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_protect_decode (
  input wire logic top_bottom,
  input wire logic [3:0] block_protect_field,
  input wire logic [8:0] sector,
  output logic protected_hit
);
  logic [9:0] span;
  logic [9:0] sector_ext;
  logic top_hit;
  logic bottom_hit;

  // Span in sectors: none, a power of two, or the whole die.
  assign span = (block_protect_field == 4'h0) ? 10'h000 :
                (block_protect_field >= fsp_pkg::BP_ALL_MIN) ? fsp_pkg::SECTOR_COUNT :
                10'(10'h001 << (block_protect_field - 4'h1));
  assign sector_ext = {1'b0, sector};
  assign top_hit = (span != 10'h000) && (sector_ext >= (fsp_pkg::SECTOR_COUNT - span));
  assign bottom_hit = sector_ext < span;
  assign protected_hit = top_bottom ? bottom_hit : top_hit;
endmodule
`default_nettype wire

//--- fsp_status_protect.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_status_protect #(
  parameter logic [15:0] WRSR_CYCLES = fsp_pkg::T_WRSR,
  parameter logic [15:0] PROG_CYCLES = fsp_pkg::T_PROG,
  parameter logic [15:0] SE4_CYCLES = fsp_pkg::T_SE4,
  parameter logic [15:0] SE32_CYCLES = fsp_pkg::T_SE32,
  parameter logic [15:0] SE64_CYCLES = fsp_pkg::T_SE64,
  parameter logic [15:0] DIE_CYCLES = fsp_pkg::T_DIE
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic wp_n,
  output logic miso,
  output logic miso_oe,
  output logic op_start,
  output logic [2:0] op_kind,
  output logic [24:0] op_addr,
  output logic [7:0] status_view,
  output logic [7:0] flag_view
);
  logic rst_a_reg, rst_b_reg, rst_n;
  logic sclk_a_reg, sclk_b_reg, sclk_c_reg;
  logic cs_a_reg, cs_b_reg, cs_c_reg;
  logic mosi_a_reg, mosi_b_reg;
  logic wp_a_reg, wp_b_reg;
  fsp_pkg::fsp_state_t state_reg, state_next;
  logic [2:0] bit_reg;
  logic [7:0] shift_reg, opcode_reg, wrsr_data_reg, rd_hold_reg;
  logic [31:0] addr_reg;
  logic [2:0] addr_cnt_reg;
  logic [1:0] data_cnt_reg;
  logic [5:0] nv_reg, nv_next;
  logic wel_reg, wel_next, busy_reg, busy_next;
  logic [15:0] timer_reg, timer_next;
  logic prot_err_reg, prog_err_reg, erase_err_reg;
  logic prot_err_next, prog_err_next, erase_err_next;
  logic op_start_next;
  logic [2:0] op_kind_next;
  logic miso_reg, miso_oe_reg;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, byte_done, frame_whole;
  logic [7:0] byte_in, status_byte, flag_byte, rd_byte;
  logic [3:0] bp_field;
  logic prot_hit, locked, can_write, has_data, addr_ok;
  logic exec_wrsr, exec_array, array_refused, die_refused;
  fsp_pkg::fsp_op_t array_kind;
  logic [15:0] array_time;

  // Reset release is synchronised; the assertion itself stays asynchronous.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_reg <= 1'b0;
      rst_b_reg <= 1'b0;
    end else begin
      rst_a_reg <= 1'b1;
      rst_b_reg <= rst_a_reg;
    end
  end
  assign rst_n = rst_b_reg;

  // Serial pins run on the host clock, so each passes two flops first.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {sclk_a_reg, sclk_b_reg, sclk_c_reg} <= 3'h0;
      {cs_a_reg, cs_b_reg, cs_c_reg} <= 3'h7;
      {mosi_a_reg, mosi_b_reg} <= 2'h0;
      {wp_a_reg, wp_b_reg} <= 2'h3;
    end else begin
      {sclk_a_reg, sclk_b_reg, sclk_c_reg} <= {sclk, sclk_a_reg, sclk_b_reg};
      {cs_a_reg, cs_b_reg, cs_c_reg} <= {cs_n, cs_a_reg, cs_b_reg};
      {mosi_a_reg, mosi_b_reg} <= {mosi, mosi_a_reg};
      {wp_a_reg, wp_b_reg} <= {wp_n, wp_a_reg};
    end
  end

  assign sclk_rise = sclk_b_reg && !sclk_c_reg && !cs_b_reg;
  assign sclk_fall = !sclk_b_reg && sclk_c_reg && !cs_b_reg;
  assign cs_fall = !cs_b_reg && cs_c_reg;
  assign cs_rise = cs_b_reg && !cs_c_reg;
  assign byte_done = sclk_rise && (bit_reg == 3'h7);
  assign byte_in = {shift_reg[6:0], mosi_b_reg};
  // A frame that ends mid-byte executes nothing.
  assign frame_whole = cs_rise && (bit_reg == 3'h0);

  assign bp_field = {nv_reg[fsp_pkg::SR_BP3 - 2], nv_reg[fsp_pkg::SR_BP_HI - 2:fsp_pkg::SR_BP_LO - 2]};
  assign status_byte = {nv_reg, wel_reg, busy_reg};
  assign flag_byte = {!busy_reg, 1'b0, erase_err_reg, prog_err_reg, 2'b00, prot_err_reg, 1'b1};
  assign rd_byte = (opcode_reg == fsp_pkg::OP_RDFS) ? flag_byte : status_byte;

  fsp_protect_decode u_decode (
    .top_bottom(nv_reg[fsp_pkg::SR_TB - 2]),
    .block_protect_field(bp_field),
    .sector(addr_reg[fsp_pkg::SECTOR_LSB +: fsp_pkg::SECTOR_W]),
    .protected_hit(prot_hit)
  );

  assign locked = nv_reg[fsp_pkg::SR_LOCK - 2] && !wp_b_reg;
  assign can_write = wel_reg && !busy_reg;
  assign has_data = data_cnt_reg != 2'h0;
  assign addr_ok = (state_reg == fsp_pkg::FSP_ST_DATA) && (addr_cnt_reg == fsp_pkg::ADDR_BYTES);
  assign exec_wrsr = frame_whole && (opcode_reg == fsp_pkg::OP_WRSR) && has_data && can_write;
  assign array_kind = (opcode_reg == fsp_pkg::OP_PP) ? fsp_pkg::FSP_OP_PROG :
                      (opcode_reg == fsp_pkg::OP_SE4) ? fsp_pkg::FSP_OP_ERASE4 :
                      (opcode_reg == fsp_pkg::OP_SE32) ? fsp_pkg::FSP_OP_ERASE32 :
                      (opcode_reg == fsp_pkg::OP_SE64) ? fsp_pkg::FSP_OP_ERASE64 :
                      (opcode_reg == fsp_pkg::OP_DIE) ? fsp_pkg::FSP_OP_DIE :
                      fsp_pkg::FSP_OP_NONE;
  assign array_time = (array_kind == fsp_pkg::FSP_OP_PROG) ? PROG_CYCLES :
                      (array_kind == fsp_pkg::FSP_OP_ERASE4) ? SE4_CYCLES :
                      (array_kind == fsp_pkg::FSP_OP_ERASE32) ? SE32_CYCLES :
                      (array_kind == fsp_pkg::FSP_OP_ERASE64) ? SE64_CYCLES : DIE_CYCLES;
  assign exec_array = frame_whole && can_write &&
                      (((array_kind == fsp_pkg::FSP_OP_PROG) && addr_ok && has_data) ||
                       ((array_kind != fsp_pkg::FSP_OP_PROG) &&
                        (array_kind != fsp_pkg::FSP_OP_NONE) &&
                        (addr_ok || (array_kind == fsp_pkg::FSP_OP_DIE))));
  assign die_refused = (array_kind == fsp_pkg::FSP_OP_DIE) && (bp_field != 4'h0);
  assign array_refused = die_refused || ((array_kind != fsp_pkg::FSP_OP_DIE) && prot_hit);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      fsp_pkg::FSP_ST_IDLE: begin
        state_next = fsp_pkg::FSP_ST_IDLE;
      end
      fsp_pkg::FSP_ST_OPCODE: begin
        if (byte_done) begin
          state_next = fsp_pkg::fsp_has_addr(byte_in) ? fsp_pkg::FSP_ST_ADDR :
                       fsp_pkg::fsp_is_read(byte_in) ? fsp_pkg::FSP_ST_READ :
                       fsp_pkg::FSP_ST_DATA;
        end
      end
      fsp_pkg::FSP_ST_ADDR: begin
        if (byte_done && (addr_cnt_reg == fsp_pkg::ADDR_BYTES - 3'h1)) begin
          state_next = fsp_pkg::FSP_ST_DATA;
        end
      end
      fsp_pkg::FSP_ST_DATA: begin
        state_next = fsp_pkg::FSP_ST_DATA;
      end
      fsp_pkg::FSP_ST_READ: begin
        state_next = fsp_pkg::FSP_ST_READ;
      end
      default: begin
        state_next = fsp_pkg::FSP_ST_IDLE;
      end
    endcase
    if (cs_fall) begin
      state_next = fsp_pkg::FSP_ST_OPCODE;
    end else if (cs_rise) begin
      state_next = fsp_pkg::FSP_ST_IDLE;
    end
  end

  // Command execution happens at deselect, and only one frame is live, so
  // no hardware set can meet a software clear in the same cycle.
  always_comb begin
    nv_next = nv_reg;
    wel_next = wel_reg;
    busy_next = busy_reg;
    timer_next = timer_reg;
    prot_err_next = prot_err_reg;
    prog_err_next = prog_err_reg;
    erase_err_next = erase_err_reg;
    op_start_next = 1'b0;
    op_kind_next = op_kind;
    if (busy_reg) begin
      timer_next = timer_reg - 16'h0001;
      if (timer_reg == 16'h0001) begin
        busy_next = 1'b0;
        wel_next = 1'b0;
      end
    end
    if (frame_whole && !busy_reg) begin
      if (opcode_reg == fsp_pkg::OP_WREN) begin
        wel_next = 1'b1;
      end
      if (opcode_reg == fsp_pkg::OP_WRDI) begin
        wel_next = 1'b0;
      end
    end
    if (frame_whole && (opcode_reg == fsp_pkg::OP_CLFS)) begin
      prot_err_next = 1'b0;
      prog_err_next = 1'b0;
      erase_err_next = 1'b0;
    end
    if (exec_wrsr && !locked) begin
      nv_next = wrsr_data_reg[7:2];
      busy_next = 1'b1;
      timer_next = WRSR_CYCLES;
      op_start_next = 1'b1;
      op_kind_next = 3'(fsp_pkg::FSP_OP_WRSR);
    end
    if (exec_array && array_refused) begin
      prot_err_next = 1'b1;
      prog_err_next = prog_err_reg || (array_kind == fsp_pkg::FSP_OP_PROG);
      erase_err_next = erase_err_reg || (array_kind != fsp_pkg::FSP_OP_PROG);
      wel_next = 1'b0;
    end else if (exec_array) begin
      busy_next = 1'b1;
      timer_next = array_time;
      op_start_next = 1'b1;
      op_kind_next = 3'(array_kind);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= fsp_pkg::FSP_ST_IDLE;
      bit_reg <= 3'h0;
      shift_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      bit_reg <= cs_fall ? 3'h0 : (sclk_rise ? bit_reg + 3'h1 : bit_reg);
      shift_reg <= sclk_rise ? byte_in : shift_reg;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      opcode_reg <= 8'h00;
      addr_reg <= 32'h0000_0000;
      addr_cnt_reg <= 3'h0;
      data_cnt_reg <= 2'h0;
      wrsr_data_reg <= 8'h00;
    end else if (cs_fall) begin
      opcode_reg <= 8'h00;
      addr_cnt_reg <= 3'h0;
      data_cnt_reg <= 2'h0;
    end else if (byte_done) begin
      if (state_reg == fsp_pkg::FSP_ST_OPCODE) begin
        opcode_reg <= byte_in;
      end
      if (state_reg == fsp_pkg::FSP_ST_ADDR) begin
        addr_reg <= {addr_reg[23:0], byte_in};
        addr_cnt_reg <= addr_cnt_reg + 3'h1;
      end
      if (state_reg == fsp_pkg::FSP_ST_DATA) begin
        data_cnt_reg <= (data_cnt_reg == 2'h3) ? data_cnt_reg : data_cnt_reg + 2'h1;
        wrsr_data_reg <= (data_cnt_reg == 2'h0) ? byte_in : wrsr_data_reg;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      nv_reg <= fsp_pkg::SR_NV_RESET;
      wel_reg <= 1'b0;
      busy_reg <= 1'b0;
      timer_reg <= 16'h0000;
      {prot_err_reg, prog_err_reg, erase_err_reg} <= 3'h0;
      op_start <= 1'b0;
      op_kind <= 3'h0;
      op_addr <= 25'h0000000;
    end else begin
      nv_reg <= nv_next;
      wel_reg <= wel_next;
      busy_reg <= busy_next;
      timer_reg <= timer_next;
      {prot_err_reg, prog_err_reg, erase_err_reg} <= {prot_err_next, prog_err_next, erase_err_next};
      op_start <= op_start_next;
      op_kind <= op_kind_next;
      op_addr <= op_start_next ? addr_reg[fsp_pkg::ADDR_W - 1:0] : op_addr;
    end
  end

  // Output bit changes on the falling edge; a fresh byte is taken at each
  // byte boundary so a polled busy bit is never torn inside one byte.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
      rd_hold_reg <= 8'h00;
    end else begin
      miso_oe_reg <= (state_next == fsp_pkg::FSP_ST_READ);
      if (sclk_fall && (state_reg == fsp_pkg::FSP_ST_READ)) begin
        rd_hold_reg <= (bit_reg == 3'h0) ? rd_byte : rd_hold_reg;
        miso_reg <= (bit_reg == 3'h0) ? rd_byte[7] : rd_hold_reg[3'h7 - bit_reg];
      end
    end
  end

  assign miso = miso_reg;
  assign miso_oe = miso_oe_reg;
  assign status_view = status_byte;
  assign flag_view = flag_byte;

  a_lock_keeps_nv: assert property (@(posedge mclk) disable iff (!rst_n)
    (exec_wrsr && locked) |=> $stable(nv_reg) && !op_start) else $error("locked status write");
  a_lock_pin_only: assert property (@(posedge mclk) disable iff (!rst_n)
    (nv_reg[5] && !wp_b_reg) |=> nv_reg[5]) else $error("lock left without pin");
  a_lock_bit_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (exec_wrsr && !locked) |=> (status_view[7:2] == $past(wrsr_data_reg[7:2])) && busy_reg)
    else $error("status write lost");
  a_top_last_sector: assert property (@(posedge mclk) disable iff (!rst_n)
    (bp_field == 4'h1 && !nv_reg[3] && addr_reg[24:16] == 9'h1ff) |-> prot_hit)
    else $error("top sector not protected");
  a_bottom_first: assert property (@(posedge mclk) disable iff (!rst_n)
    (bp_field == 4'h9 && nv_reg[3]) |-> (prot_hit == (addr_reg[24:16] < 9'h100)))
    else $error("bottom span wrong");
  a_zero_field_open: assert property (@(posedge mclk) disable iff (!rst_n)
    (bp_field == 4'h0) |-> !prot_hit) else $error("zero field protects");
  a_start_needs_wel: assert property (@(posedge mclk) disable iff (!rst_n)
    op_start |-> $past(wel_reg)) else $error("operation without latch");
  a_busy_with_start: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(busy_reg) |-> op_start) else $error("busy without start");
  a_busy_flag_pair: assert property (@(posedge mclk) disable iff (!rst_n)
    status_view[0] != flag_view[7]) else $error("busy and ready agree");
  a_die_refused: assert property (@(posedge mclk) disable iff (!rst_n)
    (exec_array && die_refused) |=> !op_start && erase_err_reg) else $error("die erase ran");
  a_prot_error: assert property (@(posedge mclk) disable iff (!rst_n)
    (exec_array && array_refused) |=> flag_view[1] && !busy_reg ##1 !op_start)
    else $error("protected target touched");
  a_wel_auto_clear: assert property (@(posedge mclk) disable iff (!rst_n)
    $fell(busy_reg) |-> !wel_reg) else $error("latch kept after operation");

  c_wrsr_done: cover property (@(posedge mclk) disable iff (!rst_n)
    op_start && op_kind == 3'h1);
  c_prot_refusal: cover property (@(posedge mclk) disable iff (!rst_n)
    exec_array && array_refused);
  c_die_erase: cover property (@(posedge mclk) disable iff (!rst_n)
    op_start && op_kind == 3'h6);
  c_read_status: cover property (@(posedge mclk) disable iff (!rst_n)
    miso_oe && sclk_fall);
endmodule
`default_nettype wire

//--- fsp_status_protect_end.sv
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

//--- fsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_host_model (
  input wire logic mclk,
  input wire logic miso,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  output logic [7:0] rx_byte
);
  // The serial clock rests low between frames, as a mode 0 host leaves it.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    rx_byte = 8'h00;
  end

  // Sends the top nbits of bits, most significant first, at 16 mclk per serial clock.
  // Stopping short of a whole byte is allowed so that partial frames can be tried.
  task automatic frame(input logic [47:0] bits, input int nbits);
    @(posedge mclk);
    cs_n <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi <= bits[47-i];
      repeat (8) @(posedge mclk);
      sclk <= 1'b1;
      rx_byte <= {rx_byte[6:0], miso};
      repeat (8) @(posedge mclk);
      sclk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    // The data line is no longer meaningful, so it is flipped rather than held.
    mosi <= ~mosi;
    cs_n <= 1'b1;
    repeat (8) @(posedge mclk);
  endtask
endmodule
`default_nettype wire

//--- fsp_status_protect_tb.sv
`timescale 1ns/1ps
`default_nettype none
module fsp_status_protect_tb;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic wp_n = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe, op_start;
  logic [2:0] op_kind;
  logic [24:0] op_addr;
  logic [7:0] status_view, flag_view, rx_byte;
  int errors = 0;
  int num_checks = 0;
  int starts = 0;
  int cycles = 0;
  int seed = 32'h00cf838c;
  int n0;
  logic [13:0] corners [10] = '{{1'b0, 4'h1, 9'h1ff}, {1'b0, 4'h1, 9'h1fe},
    {1'b0, 4'h9, 9'h100}, {1'b0, 4'h9, 9'h0ff}, {1'b1, 4'h9, 9'h0ff}, {1'b1, 4'h9, 9'h100},
    {1'b1, 4'ha, 9'h12c}, {1'b0, 4'h0, 9'h1ff}, {1'b1, 4'hf, 9'h000}, {1'b1, 4'h1, 9'h001}};

  always #2.5 mclk = ~mclk;

  // Status writes keep their default time; only the array timings are cut short.
  fsp_status_protect #(.PROG_CYCLES(16'h0014),
    .SE4_CYCLES(16'h0014), .SE32_CYCLES(16'h0014), .SE64_CYCLES(16'h0014),
    .DIE_CYCLES(16'h0014)) dut_u (.mclk(mclk), .reset_n(reset_n), .sclk(sclk),
    .cs_n(cs_n), .mosi(mosi), .wp_n(wp_n), .miso(miso), .miso_oe(miso_oe),
    .op_start(op_start), .op_kind(op_kind), .op_addr(op_addr),
    .status_view(status_view), .flag_view(flag_view));

  fsp_host_model host_u (.mclk(mclk), .miso(miso), .sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .rx_byte(rx_byte));

  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // The time limit is well above the roughly 50k cycles that the sequence needs.
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (op_start === 1'b1) starts <= starts + 1;
    if (cycles == 90000) begin
      errors++;
      wrap_up();
    end
  end

  always @(negedge mclk) if (reset_n) chk(status_view[0], !flag_view[7]);

  function automatic logic [7:0] sv(input logic lk, input logic t, input logic [3:0] bp);
    sv = {lk, bp[3], t, bp[2:0], 2'b00};
  endfunction

  function automatic logic prot(input logic t, input logic [3:0] bp, input logic [8:0] s);
    int n;
    n = (bp == 4'h0) ? 0 : (bp >= 4'ha) ? 512 : (1 << (bp - 4'h1));
    prot = t ? (int'(s) < n) : (int'(s) >= 512 - n);
  endfunction

  // Outputs are looked at on the falling edge, after the design's updates have landed.
  task automatic go(input logic [47:0] bits, input int nbits);
    host_u.frame(bits, nbits);
    @(negedge mclk);
  endtask

  task automatic wren();
    go({fsp_pkg::OP_WREN, 40'h0}, 8);
  endtask

  task automatic idle();
    for (int i = 0; i < 200 && status_view[0] !== 1'b0; i++) @(negedge mclk);
    chk(status_view[0], 1'b0);
  endtask

  task automatic wrsr(input logic [7:0] v);
    wren();
    go({fsp_pkg::OP_WRSR, v, 32'h0}, 16);
    idle();
  endtask

  task automatic rd_status(input logic [7:0] exp);
    go({fsp_pkg::OP_RDSR, 40'h0}, 16);
    chk(rx_byte, exp);
  endtask

  task automatic try_op(input logic t, input logic [3:0] bp, input logic [8:0] s, input int k);
    logic [7:0] op;
    logic [24:0] a;
    logic hit;
    op = (k == 0) ? fsp_pkg::OP_PP : (k == 1) ? fsp_pkg::OP_SE4 :
      (k == 2) ? fsp_pkg::OP_SE32 : fsp_pkg::OP_SE64;
    a = {s, 16'($random(seed))};
    hit = prot(t, bp, s);
    wrsr(sv(1'b0, t, bp));
    rd_status(sv(1'b0, t, bp));
    wren();
    n0 = starts;
    go({op, 7'($random(seed)), a, 8'h5a}, (k == 0) ? 48 : 40);
    chk(starts - n0, hit ? 0 : 1);
    if (hit) begin
      chk(flag_view, 8'h83 | ((k == 0) ? 8'h10 : 8'h20));
      chk(status_view[1], 1'b0);
      go({fsp_pkg::OP_CLFS, 40'h0}, 8);
    end else begin
      chk({op_kind, op_addr, status_view[0]}, {3'(k + 2), a, 1'b1});
      idle();
      chk(status_view[1:0], 2'b00);
    end
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (6) @(negedge mclk);
    chk(status_view, 8'h00);
    chk({miso_oe, flag_view}, 9'h081);
    // A frame that stops in mid-byte must not set the latch.
    go({fsp_pkg::OP_WREN, 40'h0}, 12);
    chk(status_view[1], 1'b0);
    // A status write without the latch is ignored.
    go({fsp_pkg::OP_WRSR, 8'h0c, 32'h0}, 16);
    rd_status(8'h00);
    foreach (corners[i]) try_op(corners[i][13], corners[i][12:9], corners[i][8:0], i % 4);
    for (int i = 0; i < 16; i++) begin
      try_op(1'($random(seed)), 4'($random(seed)), 9'($random(seed)), i % 4);
    end
    wrsr(sv(1'b0, 1'b0, 4'h1));
    wren();
    n0 = starts;
    go({fsp_pkg::OP_DIE, 40'h0}, 8);
    chk({24'(starts - n0), flag_view}, {24'h0, 8'ha3});
    go({fsp_pkg::OP_RDFS, 40'h0}, 16);
    chk(rx_byte, 8'ha3);
    go({fsp_pkg::OP_CLFS, 40'h0}, 8);
    wrsr(8'h00);
    wren();
    n0 = starts;
    go({fsp_pkg::OP_DIE, 40'h0}, 8);
    chk({24'(starts - n0), 5'(op_kind)}, {24'h1, 5'h06});
    idle();
    @(posedge mclk);
    wp_n <= 1'b0;
    wrsr(sv(1'b1, 1'b0, 4'h3));
    rd_status(sv(1'b1, 1'b0, 4'h3));
    wrsr(sv(1'b0, 1'b1, 4'h0));
    rd_status(sv(1'b1, 1'b0, 4'h3) | 8'h02);
    go({fsp_pkg::OP_WRDI, 40'h0}, 8);
    // The refused write leaves the latch that its own write enable set.
    wrsr(8'h00);
    rd_status(sv(1'b1, 1'b0, 4'h3) | 8'h02);
    @(posedge mclk);
    wp_n <= 1'b1;
    repeat (4) @(negedge mclk);
    wrsr(8'h00);
    rd_status(8'h00);
    wrap_up();
  end
endmodule
`default_nettype wire
